// ==== rtl/id_gate_map.svh ====
// Constants for the serial-mode ID code gate: flash locations, reserved words, fields.
// Assumes the includer is a design file of the gate; definitions only.
`ifndef ID_GATE_MAP_SVH
`define ID_GATE_MAP_SVH

// ----------------------------------------------------------------------------
// Flash locations
// ----------------------------------------------------------------------------
`define RESET_VECTOR_LOW 20'h0_FFFC
`define RESET_VECTOR_HIGH 20'h0_FFFE
`define RESET_VECTOR_BLANK 24'hFF_FFFF
`define OPTION_SELECT_ADDR 20'h0_FFFF
`define ID_ADDR_FIRST 20'h0_FFDF
`define ID_ADDR_THIRD 20'h0_FFEB
`define ID_ADDR_SEVENTH 20'h0_FFFB
`define ID_BYTE_COUNT 3'h7

// ----------------------------------------------------------------------------
// Reserved words, first ID byte in the low byte
// ----------------------------------------------------------------------------
`define FORCED_ERASE_WORD 56'h45_5341_5265_4C41
`define SERIAL_DISABLE_WORD 56'h74_6365_746F_7250

// ----------------------------------------------------------------------------
// Option select byte fields and protect encoding
// ----------------------------------------------------------------------------
`define PROTECT_GATE_POS 2
`define PROTECT_SELECT_POS 3
`define PROTECT_ENABLED_CODE 2'h1

`endif

// ==== rtl/id_gate_pkg.sv ====
// Types shared by the serial-mode ID code gate.
// Assumes nothing beyond a SystemVerilog compiler.
package id_gate_pkg;

   // Stored flash content captured at the gate's evaluation.
   typedef struct packed {
      logic [23:0] reset_vector;
      logic [7:0] option_select_byte;
      logic [55:0] stored_id;
   } flash_image_t;

   // Outcome of the gate.
   typedef struct packed {
      logic cmd_accept;
      logic rom_erase;
      logic serial_refused;
      logic protect_locked;
   } gate_verdict_t;

   typedef enum logic [1:0] {
      WORD_OTHER,
      WORD_ERASE,
      WORD_DISABLE
   } word_kind_t;

endpackage : id_gate_pkg

// ==== rtl/id_word_classify.sv ====
// Classifies a seven-byte ID word as forced-erase, serial-disable or other.
// Assumes a combinational context; first ID byte in bits 7:0.
`include "id_gate_map.svh"

module id_word_classify (
   input wire logic [55:0] word,
   output id_gate_pkg::word_kind_t kind
);

   always_comb
   begin
      if (word == `FORCED_ERASE_WORD)
      begin
         kind = id_gate_pkg::WORD_ERASE;
      end
      else if (word == `SERIAL_DISABLE_WORD)
      begin
         kind = id_gate_pkg::WORD_DISABLE;
      end
      else
      begin
         kind = id_gate_pkg::WORD_OTHER;
      end
   end

endmodule : id_word_classify

// ==== rtl/serial_mode_id_code_gate.sv ====
// Serial-mode ID code gate: collects seven received ID bytes and decides access.
// Assumes flash content is stable on its inputs and inputs are synchronous to core_clk.
`include "id_gate_map.svh"

// Overview of operation
// - A reset vector of all ones skips the ID check and accepts every command after the verdict unless a serial-disable word is stored.
// - Otherwise commands are acknowledged only when all seven received bytes match stored ones.
// - Any mismatching byte while checking blocks acknowledgement of all commands.
// - Seven stored ID bytes form a reserved word only if all seven match it in order.
// - The forced-erase word is A, L, e, R, A, S, E from first to seventh ID byte.
// - The serial-disable word is P, r, o, t, e, c, t from first to seventh ID byte.
// - Received and stored forced-erase words erase the whole user ROM regardless of options.
// - Received forced-erase word with other stored ID and options not 01b erases all user ROM.
// - Received forced-erase word with other stored ID and options 01b does a normal ID check.
// - Stored forced-erase word with any other received ID counts as a mismatch.
// - A stored serial-disable word refuses all serial communication.
// - Serial-disable word plus enabled protection locks out every programmer.
// - Protection is enabled only when gate bit 2 is one and select bit 3 is zero.
module serial_mode_id_code_gate (
   input wire logic core_clk,
   input wire logic srst,
   input wire id_gate_pkg::flash_image_t flash_image,
   input wire logic id_valid,
   input wire logic [7:0] id_data,
   input wire logic cmd_valid,
   output logic cmd_ack,
   output logic cmd_nak,
   output logic decided,
   output id_gate_pkg::gate_verdict_t verdict
);

   typedef enum logic [1:0] {
      ST_COLLECT,
      ST_DECIDE,
      ST_DONE
   } gate_state_t;

   gate_state_t state_q;
   logic [55:0] rx_id_q;
   logic [2:0] rx_count_q;
   id_gate_pkg::word_kind_t rx_kind;
   id_gate_pkg::word_kind_t stored_kind;
   logic blank_vector;
   logic protect_enabled;
   id_gate_pkg::gate_verdict_t verdict_d;

   // ----------------------------------------------------------------------------
   // Reserved word recognition
   // ----------------------------------------------------------------------------
   id_word_classify u_rx_class (
      .word(rx_id_q),
      .kind(rx_kind)
   );

   id_word_classify u_stored_class (
      .word(flash_image.stored_id),
      .kind(stored_kind)
   );

   // Protection is enabled only for gate one and select zero.
   function automatic logic protect_on(input logic [7:0] opt);
      protect_on = {opt[`PROTECT_SELECT_POS], opt[`PROTECT_GATE_POS]} == `PROTECT_ENABLED_CODE;
   endfunction : protect_on

   assign blank_vector = flash_image.reset_vector == `RESET_VECTOR_BLANK;
   assign protect_enabled = protect_on(flash_image.option_select_byte);

   // ----------------------------------------------------------------------------
   // Decision
   // ----------------------------------------------------------------------------
   always_comb
   begin
      verdict_d = '0;
      verdict_d.protect_locked = protect_enabled &&
         stored_kind == id_gate_pkg::WORD_DISABLE;
      if (stored_kind == id_gate_pkg::WORD_DISABLE)
      begin
         verdict_d.serial_refused = 1'b1;
      end
      else if (blank_vector)
      begin
         verdict_d.cmd_accept = 1'b1;
      end
      else if (rx_kind == id_gate_pkg::WORD_ERASE &&
               stored_kind == id_gate_pkg::WORD_ERASE)
      begin
         verdict_d.rom_erase = 1'b1;
      end
      else if (rx_kind == id_gate_pkg::WORD_ERASE && !protect_enabled)
      begin
         verdict_d.rom_erase = 1'b1;
      end
      else
      begin
         // Plain comparison; a stored erase word never matches another word.
         verdict_d.cmd_accept = rx_id_q == flash_image.stored_id;
      end
   end

   // ----------------------------------------------------------------------------
   // ID byte collection
   // ----------------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rx_id_q <= '0;
         rx_count_q <= '0;
      end
      else if (state_q == ST_COLLECT && id_valid)
      begin
         // First byte lands in the low byte, seventh in the top byte.
         rx_id_q <= {id_data, rx_id_q[55:8]};
         rx_count_q <= rx_count_q + 3'h1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_q <= ST_COLLECT;
      end
      else
      begin
         case (state_q)
            ST_COLLECT:
            begin
               if (id_valid && rx_count_q == `ID_BYTE_COUNT - 3'h1)
               begin
                  state_q <= ST_DECIDE;
               end
            end
            ST_DECIDE:
            begin
               state_q <= ST_DONE;
            end
            ST_DONE:
            begin
               state_q <= ST_DONE;
            end
            default:
            begin
               state_q <= ST_COLLECT;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         verdict <= '0;
         decided <= 1'b0;
      end
      else if (state_q == ST_DECIDE)
      begin
         verdict <= verdict_d;
         decided <= 1'b1;
      end
   end

   // Commands before the verdict are not acknowledged.
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cmd_ack <= 1'b0;
         cmd_nak <= 1'b0;
      end
      else
      begin
         cmd_ack <= cmd_valid && decided && verdict.cmd_accept;
         // A stored serial-disable word silences the link even before the verdict.
         cmd_nak <= cmd_valid && !verdict.serial_refused &&
            stored_kind != id_gate_pkg::WORD_DISABLE &&
            !(decided && verdict.cmd_accept);
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   a_blank_accepts: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && blank_vector && stored_kind != id_gate_pkg::WORD_DISABLE
      |=> verdict.cmd_accept && decided)
      else $error("blank reset vector did not accept commands");

   a_match_acks: assert property (@(posedge core_clk) disable iff (srst)
      cmd_valid && decided && verdict.cmd_accept |=> cmd_ack && !cmd_nak)
      else $error("accepted command was not acknowledged");

   a_mismatch_blocks: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && !blank_vector && rx_id_q != flash_image.stored_id &&
      rx_kind != id_gate_pkg::WORD_ERASE |=> !verdict.cmd_accept)
      else $error("mismatching ID was accepted");

   a_erase_both: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && !blank_vector && rx_kind == id_gate_pkg::WORD_ERASE &&
      stored_kind == id_gate_pkg::WORD_ERASE |=> verdict.rom_erase)
      else $error("erase word in both places did not erase");

   a_erase_unprot: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && !blank_vector && rx_kind == id_gate_pkg::WORD_ERASE &&
      stored_kind == id_gate_pkg::WORD_OTHER && !protect_enabled
      |=> verdict.rom_erase)
      else $error("unprotected forced erase not performed");

   a_erase_prot: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && rx_kind == id_gate_pkg::WORD_ERASE &&
      stored_kind == id_gate_pkg::WORD_OTHER && protect_enabled
      |=> !verdict.rom_erase)
      else $error("protected device was erased");

   a_stored_erase: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && !blank_vector && stored_kind == id_gate_pkg::WORD_ERASE &&
      rx_kind != id_gate_pkg::WORD_ERASE |=> !verdict.cmd_accept && !verdict.rom_erase)
      else $error("stored erase word let another ID through");

   a_disable_refuses: assert property (@(posedge core_clk) disable iff (srst)
      (verdict.serial_refused || stored_kind == id_gate_pkg::WORD_DISABLE) && cmd_valid
      |=> !cmd_ack && !cmd_nak)
      else $error("refused link answered a command");

   a_lock_flags: assert property (@(posedge core_clk) disable iff (srst)
      decided && verdict.protect_locked |-> verdict.serial_refused &&
      !verdict.rom_erase)
      else $error("locked device not fully refused");

   // The seventh ID byte is taken at this edge.
   sequence s_seventh_byte;
      state_q == ST_COLLECT && id_valid && rx_count_q == 3'h6;
   endsequence

   // The verdict stays hidden for one cycle and then appears.
   sequence s_verdict_out;
      ##1 !decided ##1 decided;
   endsequence

   a_seventh_decides: assert property (@(posedge core_clk) disable iff (srst)
      s_seventh_byte |-> s_verdict_out)
      else $error("verdict not given two cycles after seventh byte");

   // ----------------------------------------------------------------------------
   // Checks on decoding and answers
   // ----------------------------------------------------------------------------
   a_erase_decode: assert property (@(posedge core_clk) disable iff (srst)
      (rx_kind == id_gate_pkg::WORD_ERASE) ==
      (rx_id_q == {8'h45, 8'h53, 8'h41, 8'h52, 8'h65, 8'h4C, 8'h41}))
      else $error("received forced-erase word decoded wrongly");

   a_disable_decode: assert property (@(posedge core_clk) disable iff (srst)
      (stored_kind == id_gate_pkg::WORD_DISABLE) ==
      (flash_image.stored_id == {8'h74, 8'h63, 8'h65, 8'h74, 8'h6F, 8'h72, 8'h50}))
      else $error("stored serial-disable word decoded wrongly");

   a_protect_decode: assert property (@(posedge core_clk) disable iff (srst)
      protect_enabled == (flash_image.option_select_byte[2] &&
      !flash_image.option_select_byte[3]))
      else $error("protect enable decoded from wrong option bits");

   a_lock_set: assert property (@(posedge core_clk) disable iff (srst)
      decided && stored_kind == id_gate_pkg::WORD_DISABLE && protect_enabled
      |-> verdict.protect_locked && verdict.serial_refused && !verdict.rom_erase)
      else $error("stored disable word with protection did not lock");

   a_early_nak: assert property (@(posedge core_clk) disable iff (srst)
      cmd_valid && !decided && stored_kind != id_gate_pkg::WORD_DISABLE
      |=> cmd_nak && !cmd_ack)
      else $error("command before the verdict was not refused");

   a_one_answer: assert property (@(posedge core_clk) disable iff (srst)
      !(cmd_ack && cmd_nak))
      else $error("command both acknowledged and refused");

   a_quiet_idle: assert property (@(posedge core_clk) disable iff (srst)
      !cmd_valid |=> !cmd_ack && !cmd_nak)
      else $error("answer given without a command");

   a_verdict_holds: assert property (@(posedge core_clk) disable iff (srst)
      decided |=> decided && $stable(verdict))
      else $error("verdict changed before reset");

   a_late_bytes: assert property (@(posedge core_clk) disable iff (srst)
      state_q != ST_COLLECT |=> $stable(rx_id_q))
      else $error("ID byte taken after the seventh");

   a_refused_closed: assert property (@(posedge core_clk) disable iff (srst)
      decided && verdict.serial_refused
      |-> !verdict.cmd_accept && !verdict.rom_erase)
      else $error("refused link still accepts or erases");

   a_blank_no_erase: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && blank_vector && stored_kind != id_gate_pkg::WORD_DISABLE
      |=> !verdict.rom_erase)
      else $error("blank reset vector led to an erase");

   a_accept_match: assert property (@(posedge core_clk) disable iff (srst)
      state_q == ST_DECIDE && !blank_vector && stored_kind == id_gate_pkg::WORD_OTHER &&
      rx_id_q == flash_image.stored_id
      |=> verdict.cmd_accept)
      else $error("matching ID was not accepted");

   a_verdict_single: assert property (@(posedge core_clk) disable iff (srst)
      decided |-> !(verdict.cmd_accept && verdict.rom_erase))
      else $error("verdict both accepts and erases");

endmodule : serial_mode_id_code_gate

// ==== verification/programmer_model.sv ====
// Model of the external serial programmer that faces the ID code gate.
// Assumes the bench calls its tasks and the gate samples on rising edges.
module programmer_model (
   input wire logic core_clk,
   output logic id_valid,
   output logic [7:0] id_data,
   output logic cmd_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      id_valid = 1'b0;
      id_data = 8'h00;
      cmd_valid = 1'b0;
   end

   // All seven bytes leave back to back, first ID byte first, with no command in between.
   task automatic send_id(input logic [55:0] word);
      for (int i = 0; i < 7; i++)
      begin
         @(negedge core_clk);
         id_valid = 1'b1;
         id_data = word[8*i +: 8];
      end
      @(negedge core_clk);
      id_valid = 1'b0;
      id_data = ~id_data;
   endtask : send_id

   task automatic send_cmds(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge core_clk);
         cmd_valid = 1'b1;
      end
      @(negedge core_clk);
      cmd_valid = 1'b0;
   endtask : send_cmds
endmodule : programmer_model

// ==== verification/tb.sv ====
// Self-checking bench for the serial-mode ID code gate.
// Assumes the programmer model drives the ID and command inputs.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [55:0] ERASE_WORD = {"E", "S", "A", "R", "e", "L", "A"};
   localparam logic [55:0] LOCK_WORD = {"t", "c", "e", "t", "o", "r", "P"};
   logic core_clk;
   logic srst;
   id_gate_pkg::flash_image_t flash_image;
   logic id_valid;
   logic [7:0] id_data;
   logic cmd_valid;
   logic cmd_ack;
   logic cmd_nak;
   logic decided;
   logic decided_q;
   id_gate_pkg::gate_verdict_t verdict;
   logic [6:0] exp_q[$];
   int err_count;
   int comparisons;
   int seed;

   serial_mode_id_code_gate i_serial_mode_id_code_gate (.core_clk(core_clk), .srst(srst),
      .flash_image(flash_image), .id_valid(id_valid), .id_data(id_data),
      .cmd_valid(cmd_valid), .cmd_ack(cmd_ack), .cmd_nak(cmd_nak), .decided(decided),
      .verdict(verdict));
   programmer_model i_programmer_model (.core_clk(core_clk), .id_valid(id_valid),
      .id_data(id_data), .cmd_valid(cmd_valid));

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
      comparisons++;
      if (exp !== got)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic take(input string what, input logic [6:0] got);
      if (exp_q.size() == 0)
         check(what, 7'h00, got);
      else
         check(what, exp_q.pop_front(), got);
   endtask : take

   always @(negedge core_clk)
   begin
      if (!srst && decided === 1'b1 && decided_q !== 1'b1)
         take("verdict", {3'h0, verdict});
      if (!srst && (cmd_ack | cmd_nak) !== 1'b0)
         take("command", {1'b1, cmd_ack, cmd_nak, 4'h0});
      decided_q = decided;
   end

   function automatic logic [3:0] expect_of(input id_gate_pkg::flash_image_t fi,
      input logic [55:0] rx);
      logic en;
      en = fi.option_select_byte[2] & ~fi.option_select_byte[3];
      if (fi.stored_id === LOCK_WORD)
         return {2'h0, 1'b1, en};
      if (fi.reset_vector === 24'hFF_FFFF)
         return 4'h8;
      if (rx === ERASE_WORD && (fi.stored_id === ERASE_WORD || !en))
         return 4'h4;
      return {rx === fi.stored_id, 3'h0};
   endfunction : expect_of

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // One gate decision followed by commands
   // ----------------------------------------------------------------
   task automatic run_case(input id_gate_pkg::flash_image_t fi, input logic [55:0] rx,
      input bit early);
      logic [3:0] v;
      int n;
      v = expect_of(fi, rx);
      @(negedge core_clk);
      srst = 1'b1;
      flash_image = fi;
      repeat (2) @(negedge core_clk);
      check("reset", 7'h00, {decided, cmd_ack, cmd_nak, verdict});
      srst = 1'b0;
      if (early)
      begin
         // A stored serial-disable word gets no answer, not even a refusal.
         if (!v[1])
            exp_q.push_back(7'h50);
         i_programmer_model.send_cmds(1);
      end
      exp_q.push_back({3'h0, v});
      i_programmer_model.send_id(rx);
      n = 0;
      while (decided !== 1'b1 && n < 20)
      begin
         @(negedge core_clk);
         n++;
      end
      if (n == 20)
      begin
         err_count++;
         tally_and_finish();
      end
      if (!v[1])
         repeat (2) exp_q.push_back(v[3] ? 7'h60 : 7'h50);
      i_programmer_model.send_cmds(2);
      repeat (4) @(negedge core_clk);
      check("pending", 7'h00, 7'(exp_q.size()));
      exp_q.delete();
      $display("case done verdict %h", v);
   endtask : run_case

   initial
   begin
      id_gate_pkg::flash_image_t fi;
      logic [55:0] rx;
      logic [7:0] en_opt;
      logic [7:0] dis_opt;
      int k;
      seed = 40662;
      srst = 1'b1;
      flash_image = '0;
      decided_q = 1'b0;
      err_count = 0;
      comparisons = 0;
      repeat (5) @(negedge core_clk);
      for (int c = 0; c < 10; c++)
      begin
         fi.reset_vector = 24'($random(seed)) & 24'hFF_FFFE;
         fi.option_select_byte = 8'($random(seed));
         fi.stored_id = 56'({$random(seed), $random(seed)});
         rx = fi.stored_id;
         en_opt = (8'($random(seed)) & 8'hF3) | 8'h04;
         dis_opt = 8'($random(seed)) | 8'h08;
         k = $unsigned($random(seed)) % 7;
         if (c == 0) fi.reset_vector = 24'hFF_FFFF;
         if (c == 2) rx[8*k +: 8] = ~rx[8*k +: 8];
         if (c inside {3, 6}) fi.stored_id = ERASE_WORD;
         if (c inside {3, 4, 5}) rx = ERASE_WORD;
         if (c inside {3, 5, 8}) fi.option_select_byte = en_opt;
         if (c inside {4, 7}) fi.option_select_byte = dis_opt;
         if (c inside {7, 8, 9}) fi.stored_id = LOCK_WORD ^ (c == 9 ? 56'h20 << 48 : 56'h0);
         if (c inside {8, 9}) rx = fi.stored_id;
         run_case(fi, rx, c < 8);
      end
      tally_and_finish();
   end
endmodule : tb
